// File: logic/iofc_pkg.sv
// Constants, types and register map of the inspection I/O fault controller.
// Assumes one 200 MHz clock and a 32-bit Avalon-MM register port.
//
// Overview of operation
// - Pulse width in microseconds, 10 us minimum
// - Width runs from assertion to deassertion
// - Per generator rising or falling trigger edge
// - Shared trigger, independent polarity per generator
// - Encoder phases from isolated inputs 6, 7
// - Count all phase edges, 4x decoding
// - Delay may advance on encoder counts
// - Five select inputs read as one value
// - Latch mode: input 5 rise captures select
// - Select read gives latched and live values
// - Select bits 0-4 from isolated inputs 0-4
// - Software reads inputs, drives outputs outside safe state
// - General inputs never start a generator
// - Fault sources: shutdown, watchdog, overheat
// - Shutdown input off raises external fault
// - Halt depends on fault and bypass switch
// - Safe states need bypass off, shutdown on
// - Halted until reset after any fault but a bypassed watchdog
// - TTL safe high/low/hiz, isolated on/off
// - Bypass switch on disables shutdown mode
// - Shutdown mode sticks until reset
// - Reset only after two second press
// - Delay then width, selectable active level
// - Delay 10 us minimum, encoder from 0
// - One pulse per edge, immediate repeats
// - Stop aborts pulse, returns to idle

package iofc_pkg;
  localparam int          CLK_HZ          = 200_000_000;
  localparam int          TICK_US         = 1;
  localparam int          US_CYCLES       = CLK_HZ / 1_000_000 * TICK_US;
  localparam int          RST_HOLD_S      = 2;
  localparam int unsigned RST_HOLD_CYCLES = RST_HOLD_S * CLK_HZ;
  localparam logic [31:0] MIN_US          = 32'h0000_000A;
  localparam int          NUM_GEN         = 6;
  localparam int          NUM_TTL         = 10;
  localparam int          NUM_ISO_OUT     = 4;
  localparam int          SEL_W           = 5;
  // -----------------------------------------------------------------
  // Register map, byte addresses
  // -----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_STATUS      = 8'h04;
  localparam logic [7:0]  REG_SELECT      = 8'h08;
  localparam logic [7:0]  REG_GPIN        = 8'h0C;
  localparam logic [7:0]  REG_GPOUT       = 8'h10;
  localparam logic [7:0]  REG_TTL_SAFE    = 8'h14;
  localparam logic [7:0]  REG_ISO_SAFE    = 8'h18;
  localparam logic [7:0]  REG_ENC_COUNT   = 8'h1C;
  localparam logic [7:0]  GEN_BASE        = 8'h40;
  localparam logic [7:0]  GEN_END         = 8'hA0;
  localparam logic [3:0]  GEN_CFG         = 4'h0;
  localparam logic [3:0]  GEN_DELAY       = 4'h4;
  localparam logic [3:0]  GEN_WIDTH       = 4'h8;
  localparam int          CTRL_SHDN_BIT   = 0;
  localparam int          CTRL_LATCH_BIT  = 1;
  localparam int          SEL_LIVE_LSB    = 8;
  localparam int          GPOUT_ISO_LSB   = 4;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam logic [31:0] SAFE_RST        = 32'h0000_0000;
  localparam logic [7:0]  GPOUT_RST       = 8'h00;
  // Isolated input positions
  localparam int          ISO_LATCH       = 5;
  localparam int          ISO_ENC_A       = 6;
  localparam int          ISO_ENC_B       = 7;
  localparam int          ISO_TRIG        = 8;
  localparam int          ISO_SHDN        = 11;
  // TTL safe-state codes, 2 bits per output
  localparam logic [1:0]  SAFE_LOW        = 2'h0;
  localparam logic [1:0]  SAFE_HIGH       = 2'h1;

  typedef enum logic [2:0] {
    SRC_IMMEDIATE, SRC_TRIG0, SRC_TTL0, SRC_TTL1, SRC_ISO5, SRC_ISO8
  } iofc_trig_src_e;

  typedef struct packed {
    logic        enc_units;
    logic        active_low;
    logic        falling;
    logic [2:0]  src;
    logic        start;
  } iofc_gen_cfg_s;

  typedef struct packed {
    logic        trig0;
    logic [1:0]  ttl;
    logic [11:0] iso;
  } iofc_pins_s;
endpackage : iofc_pkg

// File: logic/iofc_pulse_gen.sv
// One timed pulse generator: delay phase, then width phase.
// Assumes fire, ticks and encoder steps are single-cycle pulses.
`timescale 1ns/1ps
module iofc_pulse_gen (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        run_in,
  input  wire logic        fire_in,
  input  wire logic        use_enc_in,
  input  wire logic        enc_step_in,
  input  wire logic        us_tick_in,
  input  wire logic        active_low_in,
  input  wire logic [31:0] delay_in,
  input  wire logic [31:0] width_in,
  output logic             pulse_out
);
  typedef enum logic [1:0] {PG_IDLE, PG_DELAY, PG_WIDTH} iofc_pg_state_e;
  iofc_pg_state_e state;
  logic [31:0]    cnt;
  logic [31:0]    dly_eff;
  logic [31:0]    wid_eff;
  logic           dstep;

  // Short width and microsecond delay settings are raised to the minimum instead of refused
  assign wid_eff = (width_in < iofc_pkg::MIN_US) ?
                   iofc_pkg::MIN_US : width_in;
  assign dly_eff = (use_enc_in || delay_in >= iofc_pkg::MIN_US) ?
                   delay_in : iofc_pkg::MIN_US;
  assign dstep   = use_enc_in ? enc_step_in : us_tick_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= PG_IDLE;
      cnt   <= 32'h0000_0000;
    end else if (!run_in) begin
      state <= PG_IDLE;
      cnt   <= 32'h0000_0000;
    end else begin
      unique case (state)
        PG_IDLE: begin
          if (fire_in) begin
            state <= PG_DELAY;
            cnt   <= 32'h0000_0000;
          end
        end
        PG_DELAY: begin
          if (cnt >= dly_eff) begin
            state <= PG_WIDTH;
            cnt   <= 32'h0000_0000;
          end else if (dstep) begin
            cnt <= cnt + 32'h0000_0001;
          end
        end
        PG_WIDTH: begin
          if (cnt >= wid_eff) begin
            state <= PG_IDLE;
            cnt   <= 32'h0000_0000;
          end else if (us_tick_in) begin
            cnt <= cnt + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= (state == PG_WIDTH) ^ active_low_in;
    end
  end
endmodule : iofc_pulse_gen

// File: logic/iofc_top.sv
// Inspection I/O fault controller: pulse generators, encoder, select
// port, general I/O and fault handling behind an Avalon-MM slave.
// Assumes pin inputs synchronous to clk_in in timing only, and a
// master that holds each request until waitrequest falls.
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module iofc_top #(
  parameter int unsigned RESET_HOLD_CYCLES = iofc_pkg::RST_HOLD_CYCLES
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic [7:0]            avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [31:0]           avs_writedata_in,
  output logic      [31:0]           avs_readdata_out,
  output logic                       avs_waitrequest_out,
  input  wire iofc_pkg::iofc_pins_s  pins_in,
  input  wire logic                  watchdog_expired_in,
  input  wire logic                  overheat_in,
  input  wire logic                  fault_bypass_switch_in,
  input  wire logic                  reset_button_in,
  output logic [9:0]                 ttl_drive_out,
  output logic [9:0]                 ttl_oe_out,
  output logic [3:0]                 iso_drive_out,
  output logic                       health_red_out,
  output logic                       system_reset_out
);
  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  localparam int NG       = iofc_pkg::NUM_GEN;
  localparam int SEL_W_M1 = iofc_pkg::SEL_W - 1;

  iofc_pkg::iofc_pins_s    sync1;
  iofc_pkg::iofc_pins_s    sync2;
  iofc_pkg::iofc_pins_s    prev;
  iofc_pkg::iofc_gen_cfg_s cfg_q   [NG];
  logic [31:0]             delay_q [NG];
  logic [31:0]             width_q [NG];
  logic [NG-1:0]           pulse;
  logic [7:0]              trig_now;
  logic [7:0]              trig_was;
  logic [7:0]              tick_cnt;
  logic                    us_tick;
  logic                    enc_a;
  logic                    enc_b;
  logic                    enc_step;
  logic [31:0]             enc_count;
  logic [31:0]             ctrl_q;
  logic [7:0]              gpout_q;
  logic [31:0]             ttl_safe_q;
  logic [31:0]             iso_safe_q;
  logic [SEL_W_M1:0]       sel_latched;
  logic                    ack_q;
  logic                    req;
  logic                    wr_en;
  logic                    gen_hit;
  logic [7:0]              gen_off;
  logic [2:0]              gen_idx;
  logic [31:0]             rd_mux;
  logic                    shdn_active;
  logic                    shdn_eff;
  logic                    ext_flag;
  logic                    wd_flag;
  logic                    oh_flag;
  logic                    halted;
  logic                    safe_q;
  logic                    soft_rst;
  logic [31:0]             press_cnt;
  logic [9:0]              ttl_norm;

  // -----------------------------------------------------------------
  // Input synchroniser
  // -----------------------------------------------------------------
  // Only sync2 is looked at; prev is a third stage for edge detection
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= pins_in;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // -----------------------------------------------------------------
  // Microsecond tick
  // -----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt <= 8'h00;
      us_tick  <= 1'b0;
    end else if (tick_cnt == 8'(iofc_pkg::US_CYCLES - 1)) begin
      tick_cnt <= 8'h00;
      us_tick  <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
      us_tick  <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Quadrature decoder
  // -----------------------------------------------------------------
  // 200 MHz sampling leaves ample margin over 400k edges per second
  assign enc_a    = sync2.iso[iofc_pkg::ISO_ENC_A];
  assign enc_b    = sync2.iso[iofc_pkg::ISO_ENC_B];
  assign enc_step = (enc_a ^ prev.iso[iofc_pkg::ISO_ENC_A]) |
                    (enc_b ^ prev.iso[iofc_pkg::ISO_ENC_B]);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      enc_count <= 32'h0000_0000;
    end else if (enc_step) begin
      if (enc_a ^ prev.iso[iofc_pkg::ISO_ENC_B]) begin
        enc_count <= enc_count + 32'h0000_0001;
      end else begin
        enc_count <= enc_count - 32'h0000_0001;
      end
    end
  end

  // -----------------------------------------------------------------
  // Trigger sources and pulse generators
  // -----------------------------------------------------------------
  // Slot 0 is immediate, slots 6 and 7 never fire; general inputs
  // have no slot at all
  assign trig_now = {2'b00, sync2.iso[iofc_pkg::ISO_TRIG],
                     sync2.iso[iofc_pkg::ISO_LATCH], sync2.ttl,
                     sync2.trig0, 1'b0};
  assign trig_was = {2'b00, prev.iso[iofc_pkg::ISO_TRIG],
                     prev.iso[iofc_pkg::ISO_LATCH], prev.ttl,
                     prev.trig0, 1'b0};

  for (genvar g = 0; g < NG; g++) begin : gen_pg
    logic rise;
    logic fall;
    logic fire;
    logic run;
    assign rise = trig_now[cfg_q[g].src] & ~trig_was[cfg_q[g].src];
    assign fall = ~trig_now[cfg_q[g].src] & trig_was[cfg_q[g].src];
    assign fire = (cfg_q[g].src == 3'(iofc_pkg::SRC_IMMEDIATE)) |
                  (cfg_q[g].falling ? fall : rise);
    assign run  = cfg_q[g].start & ~halted;

    iofc_pulse_gen u_pg (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .run_in        (run),
      .fire_in       (fire),
      .use_enc_in    (cfg_q[g].enc_units),
      .enc_step_in   (enc_step),
      .us_tick_in    (us_tick),
      .active_low_in (cfg_q[g].active_low),
      .delay_in      (delay_q[g]),
      .width_in      (width_q[g]),
      .pulse_out     (pulse[g])
    );
  end

  // -----------------------------------------------------------------
  // Avalon-MM slave
  // -----------------------------------------------------------------
  // One wait state on every access; data is taken when waitrequest
  // is low, so writes land exactly once
  assign req     = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_q;
  assign wr_en   = avs_write_in & ack_q;
  assign gen_hit = (avs_address_in >= iofc_pkg::GEN_BASE) &&
                   (avs_address_in < iofc_pkg::GEN_END);
  assign gen_off = avs_address_in - iofc_pkg::GEN_BASE;
  assign gen_idx = gen_off[6:4];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !ack_q) begin
      avs_readdata_out <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (gen_hit) begin
      unique case (gen_off[3:0])
        iofc_pkg::GEN_CFG:   rd_mux = 32'(cfg_q[gen_idx]);
        iofc_pkg::GEN_DELAY: rd_mux = delay_q[gen_idx];
        iofc_pkg::GEN_WIDTH: rd_mux = width_q[gen_idx];
        default:             rd_mux = 32'h0000_0000;
      endcase
    end else begin
      unique case (avs_address_in)
        iofc_pkg::REG_CTRL:      rd_mux = ctrl_q;
        iofc_pkg::REG_STATUS:    rd_mux = {24'h00_0000, pulse[1:0] != 2'b00,
                                   fault_bypass_switch_in, safe_q,
                                   shdn_eff, oh_flag, wd_flag, ext_flag,
                                   halted};
        iofc_pkg::REG_SELECT:    rd_mux = {19'h0_0000,
                                   sync2.iso[SEL_W_M1:0], 3'h0,
                                   sel_latched};
        iofc_pkg::REG_GPIN:      rd_mux = {17'h0_0000, sync2};
        iofc_pkg::REG_GPOUT:     rd_mux = {24'h00_0000, gpout_q};
        iofc_pkg::REG_TTL_SAFE:  rd_mux = ttl_safe_q;
        iofc_pkg::REG_ISO_SAFE:  rd_mux = iso_safe_q;
        iofc_pkg::REG_ENC_COUNT: rd_mux = enc_count;
        default:                 rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Global registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q     <= iofc_pkg::CTRL_RST;
      gpout_q    <= iofc_pkg::GPOUT_RST;
      ttl_safe_q <= iofc_pkg::SAFE_RST;
      iso_safe_q <= iofc_pkg::SAFE_RST;
    end else if (wr_en) begin
      unique case (avs_address_in)
        iofc_pkg::REG_CTRL:     ctrl_q     <= {30'h0, avs_writedata_in[1:0]};
        iofc_pkg::REG_GPOUT:    gpout_q    <= avs_writedata_in[7:0];
        iofc_pkg::REG_TTL_SAFE: ttl_safe_q <= {12'h000,
                                               avs_writedata_in[19:0]};
        iofc_pkg::REG_ISO_SAFE: iso_safe_q <= {28'h000_0000,
                                               avs_writedata_in[3:0]};
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Generator registers
  // -----------------------------------------------------------------
  // Reconfiguring while started takes effect at once; stop first
  for (genvar g = 0; g < NG; g++) begin : gen_regs
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        cfg_q[g]   <= '0;
        delay_q[g] <= iofc_pkg::MIN_US;
        width_q[g] <= iofc_pkg::MIN_US;
      end else if (wr_en && gen_hit && gen_idx == 3'(g)) begin
        unique case (gen_off[3:0])
          iofc_pkg::GEN_CFG:   cfg_q[g]   <= avs_writedata_in[6:0];
          iofc_pkg::GEN_DELAY: delay_q[g] <= avs_writedata_in;
          iofc_pkg::GEN_WIDTH: width_q[g] <= avs_writedata_in;
          default: ;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // Product select latch
  // -----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_latched <= '0;
    end else if (ctrl_q[iofc_pkg::CTRL_LATCH_BIT] &&
                 sync2.iso[iofc_pkg::ISO_LATCH] &&
                 !prev.iso[iofc_pkg::ISO_LATCH]) begin
      sel_latched <= sync2.iso[SEL_W_M1:0];
    end
  end

  // -----------------------------------------------------------------
  // Reset pushbutton
  // -----------------------------------------------------------------
  // Counter saturates so a long press gives one reset only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      press_cnt <= 32'h0000_0000;
      soft_rst  <= 1'b0;
    end else if (!reset_button_in) begin
      press_cnt <= 32'h0000_0000;
      soft_rst  <= 1'b0;
    end else begin
      soft_rst <= (press_cnt == 32'(RESET_HOLD_CYCLES - 1));
      if (press_cnt != 32'(RESET_HOLD_CYCLES)) begin
        press_cnt <= press_cnt + 32'h0000_0001;
      end
    end
  end

  assign system_reset_out = soft_rst;

  // -----------------------------------------------------------------
  // Fault handling
  // -----------------------------------------------------------------
  assign shdn_eff = shdn_active & ~fault_bypass_switch_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shdn_active <= 1'b0;
      ext_flag    <= 1'b0;
      wd_flag     <= 1'b0;
      oh_flag     <= 1'b0;
    end else if (soft_rst) begin
      shdn_active <= 1'b0;
      ext_flag    <= 1'b0;
      wd_flag     <= 1'b0;
      oh_flag     <= 1'b0;
    end else begin
      shdn_active <= shdn_active | (ctrl_q[iofc_pkg::CTRL_SHDN_BIT] &
                                    ~fault_bypass_switch_in);
      ext_flag    <= ext_flag |
                     (shdn_eff & ~sync2.iso[iofc_pkg::ISO_SHDN]);
      wd_flag     <= wd_flag | watchdog_expired_in;
      oh_flag     <= oh_flag | overheat_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      halted <= 1'b0;
      safe_q <= 1'b0;
    end else if (soft_rst) begin
      halted <= 1'b0;
      safe_q <= 1'b0;
    end else begin
      halted <= halted | ext_flag | oh_flag |
                (wd_flag & ~fault_bypass_switch_in);
      safe_q <= safe_q |
                ((ext_flag | wd_flag | oh_flag) & shdn_eff);
    end
  end

  assign health_red_out = halted;

  // -----------------------------------------------------------------
  // Output drive
  // -----------------------------------------------------------------
  assign ttl_norm = {pulse[5], pulse[4], gpout_q[2:0], pulse[3:0],
                     watchdog_expired_in};

  for (genvar t = 0; t < iofc_pkg::NUM_TTL; t++) begin : gen_ttl
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        ttl_drive_out[t] <= 1'b0;
        ttl_oe_out[t]    <= 1'b1;
      end else if (safe_q) begin
        ttl_drive_out[t] <= (ttl_safe_q[2*t +: 2] == iofc_pkg::SAFE_HIGH);
        ttl_oe_out[t]    <= (ttl_safe_q[2*t +: 2] == iofc_pkg::SAFE_HIGH) |
                            (ttl_safe_q[2*t +: 2] == iofc_pkg::SAFE_LOW);
      end else begin
        ttl_drive_out[t] <= ttl_norm[t];
        ttl_oe_out[t]    <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      iso_drive_out <= 4'h0;
    end else if (safe_q) begin
      iso_drive_out <= iso_safe_q[3:0];
    end else begin
      iso_drive_out <= gpout_q[iofc_pkg::GPOUT_ISO_LSB +: 4];
    end
  end
endmodule : iofc_top

// File: dv/iofc_asserts.sv
// Port checker for the I/O fault controller top level.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module iofc_asserts #(
  parameter int unsigned RESET_HOLD_CYCLES = 20
) (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        watchdog_expired_in,
  input wire logic        overheat_in,
  input wire logic        fault_bypass_switch_in,
  input wire logic        reset_button_in,
  input wire logic        health_red_out,
  input wire logic        system_reset_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  int unsigned hold_cnt;
  wire         req = avs_read_in | avs_write_in;
  // Press length, cleared on release
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) hold_cnt <= 0;
    else hold_cnt <= reset_button_in ? hold_cnt + 1 : 0;
  sequence s_one_wait;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  AST_BUS_WAIT: assert property ($rose(req) |-> s_one_wait)
    else $error("bus wait not one cycle");
  AST_RD_HOLD: assert property (!avs_read_in
    |=> $stable(avs_readdata_out))
    else $error("read data moved without a read");
  AST_WD_HALT: assert property (watchdog_expired_in
    && !fault_bypass_switch_in |-> ##[1:4] health_red_out)
    else $error("watchdog did not halt");
  AST_OH_HALT: assert property (overheat_in
    |-> ##[1:4] health_red_out) else $error("overheat did not halt");
  AST_BYP_NOHALT: assert property (fault_bypass_switch_in
    && !overheat_in && $past(fault_bypass_switch_in)
    && !$past(overheat_in) && !health_red_out
    |=> !health_red_out) else $error("halt without cause under bypass");
  AST_RED_STICKY: assert property (health_red_out
    && !system_reset_out && !$past(system_reset_out)
    |=> health_red_out) else $error("halt lost");
  AST_RST_HOLD: assert property ($rose(system_reset_out)
    |-> hold_cnt >= RESET_HOLD_CYCLES - 1) else $error("short press reset");
  AST_RST_PULSE: assert property (system_reset_out
    |=> !system_reset_out) else $error("reset pulse too long");
endmodule : iofc_asserts
bind iofc_top iofc_asserts #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES))
  iofc_asserts_inst (.*);

// File: dv/iofc_pins_model.sv
// Pin-side partner: sensors, encoder, select port, shutdown line.
// Assumes the bench steps it through its tasks after a clock edge.
`timescale 1ns/1ps
module iofc_pins_model (
  input  wire logic            clk_in,
  output iofc_pkg::iofc_pins_s pins_out
);
  logic [14:0] p = 15'h0800; // Shutdown line on: normal run
  logic [1:0]  s = 2'h0;
  assign pins_out = p;
  task automatic put(input int i, input logic v);
    @(posedge clk_in);
    p[i] <= v;
  endtask : put
  // Gray steps at the top legal count rate, 500 cycles each
  task automatic enc(input int n, input logic up);
    repeat (n) begin
      @(posedge clk_in);
      s = up ? s + 2'h1 : s - 2'h1;
      p[6] <= s[0] ^ s[1];
      p[7] <= s[1];
      repeat (499) @(posedge clk_in);
    end
  endtask : enc
endmodule : iofc_pins_model

// File: dv/tb_top.sv
// Self-checking bench with bus tasks and expected-value model.
// Assumes the pin model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic                 clk_in, rst_in, avs_read_in, avs_write_in;
  logic [7:0]           avs_address_in;
  logic [31:0]          avs_writedata_in, avs_readdata_out, d;
  logic                 avs_waitrequest_out, watchdog_expired_in;
  logic                 overheat_in, fault_bypass_switch_in, reset_button_in;
  logic [9:0]           ttl_drive_out, ttl_oe_out;
  logic [3:0]           iso_drive_out;
  logic                 health_red_out, system_reset_out;
  iofc_pkg::iofc_pins_s pins_in;
  int                   miscompares, compares, cyc, v, c1, n0, n1;
  int                   sel_q[$];
  iofc_pins_model pins_model_inst (.clk_in, .pins_out(pins_in));
  iofc_top #(.RESET_HOLD_CYCLES(20)) iofc_top_inst (.*);
  initial begin
    clk_in = 0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 40000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic summarize();
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] x);
    @(posedge clk_in);
    {avs_address_in, avs_writedata_in, avs_write_in, avs_read_in} <= {a, x, w, !w};
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    d = avs_readdata_out;
    {avs_write_in, avs_read_in} <= 2'h0;
  endtask : bus
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(d, e);
  endtask : rc
  task automatic press();
    reset_button_in <= 1;
    repeat (40) @(posedge clk_in);
    reset_button_in <= 0;
    repeat (8) @(posedge clk_in);
  endtask : press
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    {rst_in, avs_read_in, avs_write_in, watchdog_expired_in} = 4'h8;
    {overheat_in, fault_bypass_switch_in, reset_button_in} = 3'h2;
    {avs_address_in, avs_writedata_in} = '0;
    v = $urandom(32'hB3FCBA78);
    repeat (16) @(posedge clk_in);
    rst_in <= 0;
    rc(iofc_pkg::REG_GPOUT, 0);
    rc(8'hFC, 0);
    v = $urandom() & 255;
    bus(1, iofc_pkg::REG_GPOUT, v);
    rc(iofc_pkg::REG_GPOUT, v);
    chk({iso_drive_out, ttl_drive_out[7:5]}, {v[7:4], v[2:0]});
    bus(1, iofc_pkg::REG_CTRL, 2);
    v = $urandom() & 31;
    sel_q.push_back(v);
    for (int i = 0; i < 6; i++) pins_model_inst.put(i, i < 5 ? v[i] : 1'b1);
    repeat (8) @(posedge clk_in);
    for (int i = 0; i < 6; i++) pins_model_inst.put(i, i < 5 ? !v[i] : 1'b0);
    repeat (8) @(posedge clk_in);
    v = sel_q[$] | (sel_q[$] ^ 31) << 8;
    rc(iofc_pkg::REG_SELECT, v);
    pins_model_inst.enc(8, 1);
    bus(0, iofc_pkg::REG_ENC_COUNT, 0);
    c1 = d;
    chk(c1 == 8 || c1 == -8, 1);
    pins_model_inst.enc(4, 0);
    rc(iofc_pkg::REG_ENC_COUNT, c1 / 2);
    bus(1, iofc_pkg::GEN_BASE, 3);
    bus(1, iofc_pkg::GEN_BASE + 8'h10, 32'h13);
    for (int e = 0; e < 2; e++) begin
      pins_model_inst.put(14, !e);
      {n0, n1} = 0;
      repeat (5000) begin
        @(posedge clk_in);
        n0 += ttl_drive_out[1];
        n1 += ttl_drive_out[2];
      end
      chk((e ? n1 : n0) inside {[1800:2200]}, 1);
      chk(e ? n0 : n1, 0);
    end
    bus(1, iofc_pkg::REG_CTRL, 1);
    pins_model_inst.put(11, 0);
    watchdog_expired_in <= 1;
    repeat (9) @(posedge clk_in);
    chk(health_red_out, 0);
    {watchdog_expired_in, overheat_in} <= 2'h1;
    pins_model_inst.put(11, 1);
    overheat_in <= 0;
    repeat (4) @(posedge clk_in);
    chk(health_red_out, 1);
    press();
    chk(health_red_out, 0);
    fault_bypass_switch_in <= 0;
    bus(1, iofc_pkg::REG_TTL_SAFE, 32'h0009_5554);
    bus(1, iofc_pkg::REG_ISO_SAFE, 32'hA);
    bus(1, iofc_pkg::REG_CTRL, 1);
    pins_model_inst.put(11, 0);
    repeat (8) @(posedge clk_in);
    chk(health_red_out, 1);
    d = {iso_drive_out, ttl_oe_out, ttl_drive_out[8:0]};
    chk(d, {4'hA, 10'h1FF, 9'h1FE});
    pins_model_inst.put(11, 1);
    bus(1, iofc_pkg::REG_CTRL, 0);
    bus(0, iofc_pkg::REG_STATUS, 0);
    chk(d[4], 1);
    press();
    rc(iofc_pkg::REG_STATUS, 0);
    watchdog_expired_in <= 1;
    repeat (6) @(posedge clk_in);
    chk(health_red_out, 1);
    summarize();
  end
endmodule : tb_top
